// ### sensor_ctrl_regs.svh
`ifndef SENSOR_CTRL_REGS_SVH
`define SENSOR_CTRL_REGS_SVH

// Register byte addresses
`define ADDR_HUM_CTRL 8'hF2
`define ADDR_ACQ_CTRL 8'hF4
`define ADDR_CONFIG 8'hF5
`define ADDR_PRESS_HI 8'hF7
`define ADDR_PRESS_MID 8'hF8
`define ADDR_PRESS_LO 8'hF9
`define ADDR_TEMP_HI 8'hFA
`define ADDR_TEMP_MID 8'hFB
`define ADDR_TEMP_LO 8'hFC
`define ADDR_HUM_HI 8'hFD
`define ADDR_HUM_LO 8'hFE

// Field positions
`define ACQ_TOSR 7:5
`define ACQ_POSR 4:2
`define ACQ_MODE 1:0
`define CFG_TSB 7:5
`define CFG_FILT 4:2
`define CFG_3W 0
`define HUM_OSR 2:0

// Reset values
`define ACQ_RESET 8'h00
`define CFG_RESET 8'h00
`define HUM_RESET 3'h0
`define SKIP_20 20'h8_0000
`define SKIP_16 16'h8000

// Two-wire slave address, upper six bits
`define SLAVE_ADDR_HI 6'h3B

// Standby timing: unit of 0.5 ms, clock 40 MHz
`define STANDBY_UNIT_US 500
`define CLK_KHZ 40000
`define STANDBY_UNIT_CYCLES ((`STANDBY_UNIT_US * `CLK_KHZ + 999) / 1000)
`define TSB_UNITS_0 12'h001
`define TSB_UNITS_1 12'h07D
`define TSB_UNITS_2 12'h0FA
`define TSB_UNITS_3 12'h1F4
`define TSB_UNITS_4 12'h3E8
`define TSB_UNITS_5 12'h7D0
`define TSB_UNITS_6 12'h014
`define TSB_UNITS_7 12'h028

`endif

// ### sensor_ctrl_pkg.sv
package sensor_ctrl_pkg;
  typedef enum logic [2:0] {
    OSR_SKIP = 3'h0, OSR_X1 = 3'h1, OSR_X2 = 3'h2, OSR_X4 = 3'h3, OSR_X8 = 3'h4, OSR_X16 = 3'h5
  } osr_e;
  typedef enum logic [1:0] {PWR_SLEEP = 2'h0, PWR_FORCED = 2'h1, PWR_NORMAL = 2'h3} power_e;
  typedef enum logic [2:0] {FILT_OFF = 3'h0, FILT_2 = 3'h1, FILT_4 = 3'h2, FILT_8 = 3'h3, FILT_16 = 3'h4} filter_e;
  typedef enum logic [2:0] {I_IDLE = 3'h0, I_RX = 3'h1, I_ACK = 3'h3, I_TX = 3'h2, I_MACK = 3'h6} i2c_state_e;

  function automatic osr_e osr_decode(input logic [2:0] c);
    return (c > 3'h5) ? OSR_X16 : osr_e'(c);
  endfunction : osr_decode

  function automatic power_e power_decode(input logic [1:0] c);
    return (c == 2'h0) ? PWR_SLEEP : (c == 2'h3) ? PWR_NORMAL : PWR_FORCED;
  endfunction : power_decode

  function automatic filter_e filter_decode(input logic [2:0] c);
    return (c > 3'h4) ? FILT_16 : filter_e'(c);
  endfunction : filter_decode
endpackage : sensor_ctrl_pkg

// ### standby_timer.sv
`include "sensor_ctrl_regs.svh"
module standby_timer #(
  parameter int unsigned UNIT_CYCLES = `STANDBY_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic run,
  input wire logic arm,
  input wire logic [2:0] code,
  output logic fire
);
  import sensor_ctrl_pkg::*;
  localparam int unsigned DW = $clog2(UNIT_CYCLES + 1);

  if (UNIT_CYCLES < 2) begin : g_check
    $error("standby unit must be at least two cycles");
  end

  logic [DW-1:0] div_r;
  logic [11:0] units_r;
  logic [11:0] target;
  logic armed_r;
  logic tick;

  assign tick = (div_r == DW'(UNIT_CYCLES - 1));

  always_comb begin
    case (code)
      3'h0: target = `TSB_UNITS_0;
      3'h1: target = `TSB_UNITS_1;
      3'h2: target = `TSB_UNITS_2;
      3'h3: target = `TSB_UNITS_3;
      3'h4: target = `TSB_UNITS_4;
      3'h5: target = `TSB_UNITS_5;
      3'h6: target = `TSB_UNITS_6;
      default: target = `TSB_UNITS_7;
    endcase
  end

  // Unit enable divider, runs only while waiting
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      div_r <= '0;
    end else if (!armed_r || tick) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DW'(1);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      armed_r <= 1'h0;
      units_r <= 12'h000;
      fire <= 1'h0;
    end else begin
      fire <= 1'h0;
      if (!run) begin
        armed_r <= 1'h0;
      end else if (arm) begin
        armed_r <= 1'h1;
        units_r <= 12'h000;
      end else if (armed_r && tick) begin
        units_r <= units_r + 12'h001;
        if (units_r + 12'h001 == target) begin // [R7]
          armed_r <= 1'h0;
          fire <= 1'h1;
        end
      end
    end
  end

  fire_after_wait_a: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
    fire |-> $past(armed_r) && $past(tick) && (units_r == target))
    else $error("standby fired before its time");
  no_fire_idle_a: assert property (@(posedge clk_sys) disable iff (rst) // [R7]
    !run ##1 !run |-> !fire)
    else $error("standby fired outside normal mode");
endmodule : standby_timer

// ### sensor_ctrl_regs.sv
`include "sensor_ctrl_regs.svh"
// Overview of operation
// [R1] Humidity setting takes effect on acquisition write
// [R2] Acquisition register: temp, pressure, power fields
// [R3] Oversampling decode; skip forces result 0x80000
// [R4] Power mode: sleep, forced twice, normal
// [R5] Config writes dropped while in normal mode
// [R6] Config: standby, filter, three-wire flag bits
// [R7] Standby code sets idle time between cycles
// [R8] Filter code decode, high codes give 16
// [R9] Pressure result over three byte registers
// [R10] Temperature result over three byte registers
// [R11] Humidity result over two byte registers
// [R12] Single, paired multi-write, auto-increment reads
// [R13] Chip select low selects four/three-wire port
// [R14] Chip select low once locks out two-wire
// [R15] Host holds chip select high during reset
// [R16] Two-wire slave, clock pin input only
// [R17] Slave address 111011 plus select pin
// [R18] Host ties address select pin to level
// [R19] Serial port in clock mode 00 or 11
// [R20] Result registers ignore host writes
module sensor_ctrl_regs #(
  parameter int unsigned STANDBY_UNIT_CYCLES = `STANDBY_UNIT_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic sck_pin,
  input wire logic serial_data_pin_i,
  output logic serial_data_pin_o,
  output logic serial_data_pin_oe,
  input wire logic address_select_pin_i,
  output logic address_select_pin_o,
  output logic address_select_pin_oe,
  input wire logic chip_select_n,
  input wire logic measure_done,
  input wire logic [19:0] raw_pressure_word,
  input wire logic [19:0] raw_temperature_word,
  input wire logic [15:0] raw_humidity_word,
  output logic measure_start,
  output sensor_ctrl_pkg::osr_e temp_osr,
  output sensor_ctrl_pkg::osr_e press_osr,
  output sensor_ctrl_pkg::osr_e hum_osr,
  output sensor_ctrl_pkg::power_e power_mode,
  output sensor_ctrl_pkg::filter_e filter_coef,
  output logic three_wire_select,
  output logic two_wire_active
);
  import sensor_ctrl_pkg::*;

  // Pin synchronisers: [3] clock, [2] data, [1] chip select, [0] address select
  localparam logic [3:0] SYNC_INIT = 4'h6;
  logic [3:0] pin_raw;
  wire [3:0] sync_w;
  assign pin_raw = {sck_pin, serial_data_pin_i, chip_select_n, address_select_pin_i};

  for (genvar g = 0; g < 4; g++) begin : g_sync
    logic meta_r;
    logic stab_r;
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        meta_r <= SYNC_INIT[g];
        stab_r <= SYNC_INIT[g];
      end else begin
        meta_r <= pin_raw[g];
        stab_r <= meta_r;
      end
    end
    assign sync_w[g] = stab_r;
  end

  logic sck_s, sdi_s, csn_s, sel_s;
  logic sck_d, sdi_d, csn_d;
  assign sck_s = sync_w[3];
  assign sdi_s = sync_w[2];
  assign csn_s = sync_w[1];
  assign sel_s = sync_w[0];

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sck_d <= 1'h0;
      sdi_d <= 1'h1;
      csn_d <= 1'h1;
    end else begin
      sck_d <= sck_s;
      sdi_d <= sdi_s;
      csn_d <= csn_s;
    end
  end

  // Interface selection
  logic lock_r;
  logic spi_act, two_wire, csn_fall;
  logic sck_rise, sck_fall, i2c_start, i2c_stop;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_r <= 1'h0;
    end else if (!csn_s) begin
      lock_r <= 1'h1; // [R14]
    end
  end

  assign spi_act = !csn_s; // [R13]
  assign two_wire = csn_s && !lock_r; // [R13] [R14]
  assign two_wire_active = !lock_r;
  assign csn_fall = csn_d && !csn_s;
  assign sck_rise = sck_s && !sck_d;
  assign sck_fall = !sck_s && sck_d;
  assign i2c_start = sck_s && sck_d && sdi_d && !sdi_s;
  assign i2c_stop = sck_s && sck_d && !sdi_d && sdi_s;

  // Register storage
  logic [7:0] acq_r, cfg_r;
  logic [2:0] hum_stage_r, hum_applied_r;
  logic [19:0] press_r, temp_r;
  logic [15:0] hum_r;
  logic [7:0] rd_data_r;
  logic busy_r, meas_end, acq_wr, fire, start_c;
  power_e new_mode;

  i2c_state_e st_r;
  logic [3:0] bitcnt_r;
  logic [7:0] shift_r, addr_r, wr_data_r, rx_byte;
  logic first_r, reg_next_r, rd_mode_r, wr_stb_r, addr_ok;
  logic sda_oe_r, sdi_o_r, sdi_oe_r, sdo_o_r, sdo_oe_r;

  assign rx_byte = {shift_r[6:0], sdi_s};
  assign addr_ok = (shift_r[7:1] == {`SLAVE_ADDR_HI, sel_s}); // [R17]
  assign meas_end = measure_done && busy_r;
  assign acq_wr = wr_stb_r && (addr_r == `ADDR_ACQ_CTRL);
  assign new_mode = power_decode(wr_data_r[`ACQ_MODE]);

  assign temp_osr = osr_decode(acq_r[`ACQ_TOSR]); // [R2] [R3]
  assign press_osr = osr_decode(acq_r[`ACQ_POSR]); // [R2] [R3]
  assign hum_osr = osr_decode(hum_applied_r);
  assign power_mode = power_decode(acq_r[`ACQ_MODE]); // [R4]
  assign filter_coef = filter_decode(cfg_r[`CFG_FILT]); // [R8]
  assign three_wire_select = cfg_r[`CFG_3W]; // [R6]

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acq_r <= `ACQ_RESET;
      cfg_r <= `CFG_RESET;
      hum_stage_r <= `HUM_RESET;
      hum_applied_r <= `HUM_RESET;
    end else begin
      if (meas_end && power_mode == PWR_FORCED) begin
        acq_r[`ACQ_MODE] <= 2'h0;
      end
      if (wr_stb_r) begin
        if (addr_r == `ADDR_ACQ_CTRL) begin
          acq_r <= wr_data_r; // [R2]
          hum_applied_r <= hum_stage_r; // [R1]
        end else if (addr_r == `ADDR_HUM_CTRL) begin
          hum_stage_r <= wr_data_r[`HUM_OSR]; // [R1]
        end else if (addr_r == `ADDR_CONFIG && power_mode != PWR_NORMAL) begin
          cfg_r <= wr_data_r; // [R5] [R6]
        end
      end
    end
  end

  // Results change only on capture, never from host writes
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      press_r <= `SKIP_20;
      temp_r <= `SKIP_20;
      hum_r <= `SKIP_16;
    end else if (meas_end) begin // [R20]
      press_r <= (press_osr == OSR_SKIP) ? `SKIP_20 : raw_pressure_word; // [R3]
      temp_r <= (temp_osr == OSR_SKIP) ? `SKIP_20 : raw_temperature_word; // [R3]
      hum_r <= (hum_osr == OSR_SKIP) ? `SKIP_16 : raw_humidity_word;
    end
  end

  // Measurement sequencing
  assign start_c = !busy_r && ((acq_wr && new_mode == PWR_FORCED)
    || (acq_wr && new_mode == PWR_NORMAL && power_mode != PWR_NORMAL) || fire); // [R4]

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      busy_r <= 1'h0;
      measure_start <= 1'h0;
    end else begin
      measure_start <= start_c;
      if (start_c) begin
        busy_r <= 1'h1;
      end else if (measure_done) begin
        busy_r <= 1'h0;
      end
    end
  end

  standby_timer #(
    .UNIT_CYCLES(STANDBY_UNIT_CYCLES)
  ) u_standby (
    .clk_sys(clk_sys),
    .rst(rst),
    .run(power_mode == PWR_NORMAL),
    .arm(meas_end),
    .code(cfg_r[`CFG_TSB]),
    .fire(fire)
  );

  // Read data, registered
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data_r <= 8'h00;
    end else if (addr_r == `ADDR_HUM_CTRL) begin
      rd_data_r <= {5'h00, hum_stage_r};
    end else if (addr_r == `ADDR_ACQ_CTRL) begin
      rd_data_r <= acq_r;
    end else if (addr_r == `ADDR_CONFIG) begin
      rd_data_r <= cfg_r;
    end else if (addr_r == `ADDR_PRESS_HI) begin
      rd_data_r <= press_r[19:12]; // [R9]
    end else if (addr_r == `ADDR_PRESS_MID) begin
      rd_data_r <= press_r[11:4]; // [R9]
    end else if (addr_r == `ADDR_PRESS_LO) begin
      rd_data_r <= {press_r[3:0], 4'h0}; // [R9]
    end else if (addr_r == `ADDR_TEMP_HI) begin
      rd_data_r <= temp_r[19:12]; // [R10]
    end else if (addr_r == `ADDR_TEMP_MID) begin
      rd_data_r <= temp_r[11:4]; // [R10]
    end else if (addr_r == `ADDR_TEMP_LO) begin
      rd_data_r <= {temp_r[3:0], 4'h0}; // [R10]
    end else if (addr_r == `ADDR_HUM_HI) begin
      rd_data_r <= hum_r[15:8]; // [R11]
    end else if (addr_r == `ADDR_HUM_LO) begin
      rd_data_r <= hum_r[7:0]; // [R11]
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  // Serial engine for both host ports; data sampled on clock rise, driven on fall
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_r <= I_IDLE;
      bitcnt_r <= 4'h0;
      shift_r <= 8'h00;
      addr_r <= 8'h00;
      first_r <= 1'h0;
      reg_next_r <= 1'h1;
      rd_mode_r <= 1'h0;
      wr_stb_r <= 1'h0;
      wr_data_r <= 8'h00;
      sda_oe_r <= 1'h0;
      sdo_o_r <= 1'h0;
      sdo_oe_r <= 1'h0;
      sdi_o_r <= 1'h0;
      sdi_oe_r <= 1'h0;
    end else begin
      wr_stb_r <= 1'h0;
      if (spi_act) begin // [R19]
        st_r <= I_IDLE;
        sda_oe_r <= 1'h0;
        sdo_oe_r <= !cfg_r[`CFG_3W]; // [R6]
        sdi_oe_r <= cfg_r[`CFG_3W] && rd_mode_r;
        if (csn_fall) begin
          bitcnt_r <= 4'h0;
          reg_next_r <= 1'h1;
          rd_mode_r <= 1'h0;
        end else if (sck_rise) begin
          shift_r <= rx_byte;
          bitcnt_r <= {1'h0, bitcnt_r[2:0] + 3'h1};
          if (bitcnt_r[2:0] == 3'h7) begin
            if (rd_mode_r) begin
              addr_r <= addr_r + 8'h01; // [R12]
            end else if (reg_next_r) begin
              addr_r <= {1'h1, rx_byte[6:0]};
              rd_mode_r <= rx_byte[7];
              reg_next_r <= 1'h0;
            end else begin
              wr_stb_r <= 1'h1; // [R12]
              wr_data_r <= rx_byte;
              reg_next_r <= 1'h1;
            end
          end
        end else if (sck_fall && rd_mode_r) begin
          sdo_o_r <= rd_data_r[~bitcnt_r[2:0]];
          sdi_o_r <= rd_data_r[~bitcnt_r[2:0]];
        end
      end else if (two_wire) begin // [R16]
        sdo_oe_r <= 1'h0;
        sdi_oe_r <= 1'h0;
        sdi_o_r <= 1'h0;
        if (i2c_start) begin
          st_r <= I_RX;
          bitcnt_r <= 4'h0;
          first_r <= 1'h1;
          sda_oe_r <= 1'h0;
        end else if (i2c_stop) begin
          st_r <= I_IDLE;
          sda_oe_r <= 1'h0;
        end else begin
          case (st_r)
            I_RX: begin
              if (sck_rise) begin
                shift_r <= rx_byte;
                bitcnt_r <= bitcnt_r + 4'h1;
              end else if (sck_fall && bitcnt_r == 4'h8) begin
                bitcnt_r <= 4'h0;
                st_r <= I_ACK;
                sda_oe_r <= 1'h1;
                if (first_r) begin
                  first_r <= 1'h0;
                  rd_mode_r <= shift_r[0];
                  reg_next_r <= 1'h1;
                  if (!addr_ok) begin // [R17]
                    st_r <= I_IDLE;
                    sda_oe_r <= 1'h0;
                  end
                end else if (reg_next_r) begin
                  addr_r <= shift_r;
                  reg_next_r <= 1'h0;
                end else begin
                  wr_stb_r <= 1'h1; // [R12]
                  wr_data_r <= shift_r;
                  reg_next_r <= 1'h1;
                end
              end
            end
            I_ACK: begin
              if (sck_fall) begin
                bitcnt_r <= 4'h0;
                st_r <= rd_mode_r ? I_TX : I_RX;
                sda_oe_r <= rd_mode_r && !rd_data_r[7];
              end
            end
            I_TX: begin
              if (sck_rise) begin
                bitcnt_r <= bitcnt_r + 4'h1;
              end else if (sck_fall) begin
                if (bitcnt_r == 4'h8) begin
                  st_r <= I_MACK;
                  sda_oe_r <= 1'h0;
                  addr_r <= addr_r + 8'h01; // [R12]
                end else begin
                  sda_oe_r <= !rd_data_r[~bitcnt_r[2:0]];
                end
              end
            end
            I_MACK: begin
              if (sck_rise && sdi_s) begin
                st_r <= I_IDLE;
              end else if (sck_fall) begin
                st_r <= I_TX;
                bitcnt_r <= 4'h0;
                sda_oe_r <= !rd_data_r[7];
              end
            end
            default: begin
              sda_oe_r <= 1'h0;
            end
          endcase
        end
      end else begin
        st_r <= I_IDLE;
        sda_oe_r <= 1'h0;
        sdo_oe_r <= 1'h0;
        sdi_oe_r <= 1'h0;
      end
    end
  end

  // Two-wire data is open drain: pulled low only
  assign serial_data_pin_o = sdi_o_r;
  assign serial_data_pin_oe = sda_oe_r || sdi_oe_r;
  assign address_select_pin_o = sdo_o_r;
  assign address_select_pin_oe = sdo_oe_r;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  lock_sticky_a: assert property (lock_r |=> lock_r) // [R14]
    else $error("two-wire lock released");
  lock_on_select_a: assert property (!csn_s |=> lock_r && !two_wire_active) // [R13]
    else $error("chip select low did not lock out two-wire");
  cfg_guard_a: assert property (wr_stb_r && addr_r == `ADDR_CONFIG && power_mode == PWR_NORMAL // [R5]
    |=> cfg_r == $past(cfg_r))
    else $error("config changed in normal mode");
  hum_apply_a: assert property (!acq_wr |=> $stable(hum_applied_r)) // [R1]
    else $error("humidity setting applied without acquisition write");
  result_ro_a: assert property (!meas_end |=> $stable(press_r) && $stable(temp_r) && $stable(hum_r)) // [R20]
    else $error("result register changed without capture");
  skip_force_a: assert property (meas_end && acq_r[`ACQ_POSR] == 3'h0 |=> press_r == `SKIP_20) // [R3]
    else $error("skipped pressure not forced");
  idle_release_a: assert property (st_r == I_IDLE && !spi_act |-> !serial_data_pin_oe) // [R16]
    else $error("data line driven while two-wire idle");
  addr_match_a: assert property ($past(st_r) == I_RX && st_r == I_ACK && $past(first_r) // [R17]
    |-> $past(addr_ok))
    else $error("acknowledged a foreign slave address");
  spi_incr_a: assert property (spi_act && !csn_fall && sck_rise && rd_mode_r && bitcnt_r[2:0] == 3'h7 // [R12]
    |=> addr_r == $past(addr_r) + 8'h01)
    else $error("read address did not advance");
  forced_start_a: assert property (acq_wr && new_mode == PWR_FORCED && !busy_r // [R4]
    |=> measure_start ##1 busy_r)
    else $error("forced write did not start a measurement");
  press_map_a: assert property (addr_r == `ADDR_PRESS_LO ##1 $stable(addr_r) && $stable(press_r) // [R9]
    |-> rd_data_r == {press_r[3:0], 4'h0})
    else $error("pressure low nibble misplaced");
endmodule : sensor_ctrl_regs

// ### serial_host.sv
module serial_host (
  output logic sck,
  output logic sdi_drv,
  output logic sdi_oe,
  output logic cs_n,
  input wire logic miso,
  input wire logic sda_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // Serial clock level between frames: high for mode 11, low for mode 00
  logic idle_sck;

  initial begin
    idle_sck = 1'b1;
    sck = 1'b1;
    sdi_drv = 1'b1;
    sdi_oe = 1'b0;
    cs_n = 1'b1;
  end

  task automatic spi_begin;
    cs_n = 1'b0;
    sdi_oe = 1'b1;
    #100;
  endtask : spi_begin

  task automatic spi_mode(input logic pol);
    idle_sck = pol;
    sck = pol;
    #100;
  endtask : spi_mode

  // Data set on fall, taken on rise, in either clock mode
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      sck = 1'b0;
      sdi_drv = tx[i];
      #100;
      sck = 1'b1;
      rx[i] = miso;
      #100;
    end
  endtask : spi_byte

  task automatic spi_end;
    #100;
    sck = idle_sck;
    #100;
    cs_n = 1'b1;
    sdi_drv = ~sdi_drv;
    #200;
  endtask : spi_end

  task automatic i2c_start;
    sdi_oe = 1'b0;
    #100;
    sdi_drv = 1'b0;
    sdi_oe = 1'b1;
    #100;
    sck = 1'b0;
  endtask : i2c_start

  // Data moves 25 ns after the fall, never while the clock is high
  task automatic i2c_byte(input logic [7:0] tx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #25;
      sdi_oe = ~tx[i];
      #75;
      sck = 1'b1;
      #100;
      sck = 1'b0;
    end
    #25;
    sdi_oe = 1'b0;
    #75;
    sck = 1'b1;
    #50;
    ack = ~sda_in;
    #50;
    sck = 1'b0;
  endtask : i2c_byte

  // Master read: data released while clock low, sampled mid-high, then ACK or NACK
  task automatic i2c_read(input logic more, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      #25;
      sdi_oe = 1'b0;
      #75;
      sck = 1'b1;
      #50;
      rx[i] = sda_in;
      #50;
      sck = 1'b0;
    end
    #25;
    sdi_oe = more;
    #75;
    sck = 1'b1;
    #100;
    sck = 1'b0;
  endtask : i2c_read

  task automatic i2c_stop;
    #25;
    sdi_oe = 1'b1;
    #75;
    sck = 1'b1;
    #100;
    sdi_oe = 1'b0;
    #100;
  endtask : i2c_stop
endmodule : serial_host

// ### test_sensor_ctrl_regs.sv
module test_sensor_ctrl_regs;
  timeunit 1ns;
  timeprecision 100ps;
  import sensor_ctrl_pkg::*;

  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic measure_done = 1'b0;
  logic addr_sel = 1'b1;
  logic [19:0] raw_p = 20'h0_0000;
  logic [19:0] raw_t = 20'h0_0000;
  logic [15:0] raw_h = 16'h0000;
  logic sck, sdi_drv, sdi_oe, cs_n, sdo_o, sdo_oe, asel_o, asel_oe;
  logic measure_start, three_wire_select, two_wire_active, sda_wire, asel_wire, ack;
  osr_e temp_osr, press_osr, hum_osr;
  power_e power_mode;
  filter_e filter_coef;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;
  int starts = 0;
  int n;
  logic [7:0] rbuf [8];
  logic [7:0] rx, v;
  logic [63:0] exp_res;

  always #12.5 clk_sys = ~clk_sys;

  // Open-drain data wire; address pin tied to a fixed level by the board
  assign sda_wire = (sdi_oe ? sdi_drv : 1'b1) & (sdo_oe ? sdo_o : 1'b1);
  assign asel_wire = asel_oe ? asel_o : addr_sel;

  sensor_ctrl_regs #(.STANDBY_UNIT_CYCLES(4)) sensor_ctrl_regs_i (
    .clk_sys(clk_sys), .rst(rst), .sck_pin(sck), .serial_data_pin_i(sda_wire),
    .serial_data_pin_o(sdo_o), .serial_data_pin_oe(sdo_oe), .address_select_pin_i(asel_wire),
    .address_select_pin_o(asel_o), .address_select_pin_oe(asel_oe), .chip_select_n(cs_n),
    .measure_done(measure_done), .raw_pressure_word(raw_p), .raw_temperature_word(raw_t),
    .raw_humidity_word(raw_h), .measure_start(measure_start), .temp_osr(temp_osr),
    .press_osr(press_osr), .hum_osr(hum_osr), .power_mode(power_mode), .filter_coef(filter_coef),
    .three_wire_select(three_wire_select), .two_wire_active(two_wire_active)
  );

  serial_host serial_host_i (
    .sck(sck), .sdi_drv(sdi_drv), .sdi_oe(sdi_oe), .cs_n(cs_n), .miso(asel_wire), .sda_in(sda_wire)
  );

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk

  task automatic do_reset;
    rst = 1'b1;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask : do_reset

  task automatic pulse_done;
    @(negedge clk_sys);
    measure_done = 1'b1;
    @(negedge clk_sys);
    measure_done = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : pulse_done

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    serial_host_i.spi_begin();
    serial_host_i.spi_byte({1'b0, a[6:0]}, rx);
    serial_host_i.spi_byte(d, rx);
    serial_host_i.spi_end();
  endtask : wr

  task automatic rd(input logic [7:0] a, input int cnt);
    serial_host_i.spi_begin();
    serial_host_i.spi_byte({1'b1, a[6:0]}, rx);
    for (int i = 0; i < cnt; i++) begin
      serial_host_i.spi_byte(8'hFF, rbuf[i]);
    end
    serial_host_i.spi_end();
  endtask : rd

  always @(negedge clk_sys) begin
    cycles++;
    if (measure_start === 1'b1) begin
      starts++;
    end
    if (cycles == 40000) begin
      fails++;
      $display("unexpected at %0t: run too long", $time);
      give_verdict();
    end
  end

  initial begin
    do_reset();
    chk(power_mode, PWR_SLEEP);
    chk(two_wire_active, 1);
    serial_host_i.i2c_start();
    serial_host_i.i2c_byte(8'hEC, ack);
    serial_host_i.i2c_stop();
    chk(ack, 0);
    serial_host_i.i2c_start();
    serial_host_i.i2c_byte(8'hEE, ack);
    chk(ack, 1);
    serial_host_i.i2c_byte(8'hF4, ack);
    serial_host_i.i2c_byte(8'h44, ack);
    serial_host_i.i2c_stop();
    chk(temp_osr, OSR_X2);
    chk(press_osr, OSR_X1);
    serial_host_i.i2c_start();
    serial_host_i.i2c_byte(8'hEE, ack);
    serial_host_i.i2c_byte(8'hF4, ack);
    serial_host_i.i2c_stop();
    serial_host_i.i2c_start();
    serial_host_i.i2c_byte(8'hEF, ack);
    chk(ack, 1);
    serial_host_i.i2c_read(1'b1, v);
    chk(v, 8'h44);
    serial_host_i.i2c_read(1'b0, v);
    chk(v, 8'h00);
    serial_host_i.i2c_stop();
    addr_sel = 1'b0;
    serial_host_i.i2c_start();
    serial_host_i.i2c_byte(8'hEC, ack);
    serial_host_i.i2c_stop();
    chk(ack, 1);
    do_reset();
    chk(temp_osr, OSR_SKIP);
    serial_host_i.spi_begin();
    serial_host_i.spi_end();
    chk(two_wire_active, 0);
    serial_host_i.i2c_start();
    serial_host_i.i2c_byte(8'hEC, ack);
    serial_host_i.i2c_stop();
    chk(ack, 0);
    for (int c = 0; c < 8; c++) begin
      v = {c[2:0], c[2:0], c[1:0]};
      wr(8'hF4, v);
      chk(temp_osr, (c > 5) ? 5 : c);
      chk(press_osr, (c > 5) ? 5 : c);
      chk(power_mode, (c[1:0] == 2'd0) ? 0 : (c[1:0] == 2'd3) ? 3 : 1);
      rd(8'hF4, 1);
      chk(rbuf[0], v);
    end
    wr(8'hF5, 8'h10);
    chk(filter_coef, FILT_OFF);
    wr(8'hF4, 8'h00);
    pulse_done();
    for (int c = 0; c < 8; c++) begin
      v = {c[2:0], c[2:0], 2'b00};
      wr(8'hF5, v);
      chk(filter_coef, (c > 4) ? 4 : c);
      rd(8'hF5, 1);
      chk(rbuf[0], v);
    end
    wr(8'hF5, 8'h01);
    chk(three_wire_select, 1);
    wr(8'hF5, 8'h00);
    chk(three_wire_select, 0);
    wr(8'hF2, 8'h03);
    chk(hum_osr, OSR_SKIP);
    n = starts;
    wr(8'hF4, 8'h05);
    chk(hum_osr, OSR_X4);
    chk(starts > n, 1);
    raw_p = 20'hA_BCDE;
    raw_t = 20'h1_2345;
    raw_h = 16'h9876;
    pulse_done();
    chk(power_mode, PWR_SLEEP);
    // Temperature skipped, so it reads the skip marker
    exp_res = {8'hAB, 8'hCD, 8'hE0, 8'h80, 8'h00, 8'h00, 8'h98, 8'h76};
    rd(8'hF7, 8);
    for (int i = 0; i < 8; i++) begin
      chk(rbuf[i], exp_res[63 - 8 * i -: 8]);
    end
    serial_host_i.spi_mode(1'b0);
    wr(8'hF8, 8'h5A);
    rd(8'hF8, 1);
    chk(rbuf[0], 8'hCD);
    // Standby code 110 is 10 ms: 20 units of 4 cycles after each capture
    wr(8'hF5, 8'hC0);
    wr(8'hF4, 8'h27);
    n = starts;
    pulse_done();
    repeat (70) @(negedge clk_sys);
    chk(starts, n);
    repeat (20) @(negedge clk_sys);
    chk(starts, n + 1);
    give_verdict();
  end
endmodule : test_sensor_ctrl_regs
